// ### rtl/card_feed_consts.svh
// Purpose: Offsets, field positions, reset values and timing figures of the card feed sequencer
// Assumes: 100 MHz system clock
// Notes:   Included by bare name; definitions only
`ifndef CARD_FEED_CONSTS_SVH
`define CARD_FEED_CONSTS_SVH

// Register word offsets on the plain register port
`define CF_OFS_CMD_ADDR   4'h0
`define CF_OFS_DATA_ADDR  4'h1
`define CF_OFS_LINE_ADDR  4'h2
`define CF_OFS_START      4'h3
`define CF_OFS_TEST       4'h4
`define CF_OFS_STATUS     4'h5

// Field positions
`define CF_START_LOCATE   0
`define CF_TEST_NOT_ALIGN 0

// Reset values and byte codes
`define CF_ADDR_RST       16'h0000
`define CF_BLANK_BYTE     8'h40
`define CF_DIGIT_ZONE     4'hF
`define CF_DIGIT_MAX      4'h9

// Timing figures in ms and the clock rate in kHz
`define CF_DRIVE_MS       45
`define CF_HOLD_MS        55
`define CF_CLK_KHZ        100000

`endif

// ### rtl/card_feed_pkg.sv
// Purpose: Types shared by the card feed sequencer and its ID assembler
// Assumes: Constants come from card_feed_consts.svh
// Notes:   All state of each module is one packed struct
package card_feed_pkg;

   typedef enum logic [1:0] {st_idle, st_feed, st_hold} seq_e;

   // One pending cycle steal toward main storage
   typedef struct packed {
      logic        req;
      logic [15:0] addr;
      logic [7:0]  data;
   } steal_s;

   // ID assembler state
   typedef struct packed {
      logic       odd_done;
      logic [1:0] high_bits;
      logic       valid;
      logic [7:0] byte_out;
   } asm_state_s;

   // Sequencer state
   typedef struct packed {
      seq_e        seq;
      logic        locate;
      logic        busy;
      logic        id_busy;
      logic        unit_chk;
      logic        drive_err;
      logic        mark_err;
      logic        clutch;
      logic        stop_req;
      logic        got_pulse;
      logic [7:0]  line;
      logic [3:0]  digit;
      logic [1:0]  miss;
      logic        skip;
      logic        skip_wait;
      logic [7:0]  eject_left;
      logic [22:0] timer;
      logic [15:0] cmd_a;
      logic [15:0] dat_a;
      logic [15:0] lin_a;
      steal_s      st;
      logic [15:0] rdata;
      logic        attn;
      logic        gate;
      logic        blk_b;
   } seq_state_s;

endpackage

// ### rtl/id_assembler.sv
// Purpose: Builds one ID byte from two sensed lines, high bits on odd lines, low bits on even lines
// Assumes: line_i is a one-cycle pulse per ID line, bits_i valid with it
// Notes:   A nibble above 9 is taken as a blank digit
`timescale 1ns/1ps
`include "card_feed_consts.svh"
module id_assembler
   import card_feed_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       reset_i,
   // Sensed lines
   input  wire logic       clear_i,
   input  wire logic       line_i,
   input  wire logic [1:0] bits_i,
   // Assembled byte
   output logic            byte_valid_o,
   output logic [7:0]      byte_o
);

   asm_state_s q;
   asm_state_s nxt_q;

   // Digit code: blank gives 40, 0..9 give F0..F9
   function automatic logic [7:0] encode(input logic [3:0] nib);
      if (nib > `CF_DIGIT_MAX)
         encode = `CF_BLANK_BYTE;
      else
         encode = {`CF_DIGIT_ZONE, nib};
   endfunction

   // Odd line keeps 8 and 4 bits, even line completes the byte
   always_comb
   begin
      nxt_q       = q;
      nxt_q.valid = 1'b0;
      if (clear_i)
      begin
         nxt_q.odd_done = 1'b0;
      end
      else if (line_i && !q.odd_done)
      begin
         nxt_q.odd_done  = 1'b1;
         nxt_q.high_bits = bits_i;
      end
      else if (line_i)
      begin
         nxt_q.odd_done = 1'b0;
         nxt_q.valid    = 1'b1;
         nxt_q.byte_out = encode({q.high_bits, bits_i});
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
         q <= '0;
      else
         q <= nxt_q;
   end

   assign byte_valid_o = q.valid;
   assign byte_o       = q.byte_out;

   a_blank_code: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (line_i && q.odd_done && !clear_i && {q.high_bits, bits_i} > 4'h9) |=> byte_o == 8'h40)
      else $error("blank digit not coded as 40");

endmodule

// ### rtl/card_feed_seq.sv
// Purpose: Sequencer for feed-read-locate and feed-read-eject of the ledger card feed unit
// Assumes: Mechanism pulses are one-cycle, synchronous; storage acks a steal within a line time
// Notes:   Operation
// Operation
// - Two missing marks: stop at next line
// - Late mark adds one extra line
// - Eject skips marks, feeds card out
// - Both operations store ID in storage
// - Line address used only when locating
// - Not-aligned test: block B, lamp, gate
// - ID busy drops when ID stored
// - Blank card: 40 bytes, stop after two lines
// - Locate steals start after second miss
// - Blank digit 40, digits F0 to F9
// - No timing pulse in 45 ms: error
// - Busy from start until hold expires
`timescale 1ns/1ps
`include "card_feed_consts.svh"
module card_feed_seq
   import card_feed_pkg::*;
#(
   parameter int ID_DIGITS   = 10,
   parameter int ID_FIRST    = 2,
   parameter int EJECT_LINES = 56,
   parameter int DRIVE_CYC   = `CF_DRIVE_MS * `CF_CLK_KHZ,
   parameter int HOLD_CYC    = `CF_HOLD_MS * `CF_CLK_KHZ
)
(
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        reset_i,
   // Register port
   input  wire logic [3:0]  addr_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic [15:0]      rdata_o,
   // Card feed mechanism
   input  wire logic        timing_pulse_i,
   input  wire logic        stop_pulse_i,
   input  wire logic [1:0]  id_bits_i,
   input  wire logic        mark_i,
   input  wire logic        mark_late_i,
   input  wire logic        card_in_i,
   output logic             clutch_o,
   output logic             card_gate_raise_o,
   output logic             attn_lamp_o,
   // Processor status lines
   output logic             busy_o,
   output logic             block_cond_b_o,
   // Cycle steal port
   output logic             steal_req_o,
   output logic [15:0]      steal_addr_o,
   output logic [7:0]       steal_data_o,
   input  wire logic        steal_ack_i
);

   localparam logic [7:0] ID_START = 8'(ID_FIRST);
   localparam logic [7:0] ID_END   = 8'(ID_FIRST + 2 * ID_DIGITS);

   // Counters and fields are sized for the defaults with room to spare
   if (ID_DIGITS < 1 || ID_DIGITS > 15 || ID_FIRST < 1 || ID_FIRST + 2 * ID_DIGITS > 200)
      $error("ID geometry out of range");
   if (EJECT_LINES < 1 || EJECT_LINES > 255 || DRIVE_CYC < 2 || HOLD_CYC < 2
       || DRIVE_CYC >= 2 ** 23 || HOLD_CYC >= 2 ** 23)
      $error("line or timer count out of range");

   seq_state_s q;
   seq_state_s nxt_q;
   logic       byte_valid;
   logic [7:0] id_byte;
   logic       start_wr;
   logic       id_line;
   logic       past_id;
   logic       line_pulse;

   assign start_wr   = wr_i && addr_i == `CF_OFS_START && !q.busy;
   assign line_pulse = q.seq == st_feed && timing_pulse_i;
   assign id_line    = line_pulse && q.line >= ID_START && q.line < ID_END;
   assign past_id    = q.line >= ID_END;

   // Byte assembly from sense cells 1 and 2
   id_assembler u_asm (
      .clk_sys_i    (clk_sys_i),
      .reset_i      (reset_i),
      .clear_i      (start_wr),
      .line_i       (id_line),
      .bits_i       (id_bits_i),
      .byte_valid_o (byte_valid),
      .byte_o       (id_byte)
   );

   // Whole sequencer: registers, feed control, mark search, steals
   always_comb
   begin
      nxt_q = q;
      if (steal_ack_i)
         nxt_q.st.req = 1'b0;

      // Register writes; start is refused while busy
      if (wr_i)
      begin
         unique case (addr_i)
            `CF_OFS_CMD_ADDR:  nxt_q.cmd_a = wdata_i;
            `CF_OFS_DATA_ADDR: nxt_q.dat_a = wdata_i;
            `CF_OFS_LINE_ADDR: nxt_q.lin_a = wdata_i;
            `CF_OFS_TEST:
               if (wdata_i[`CF_TEST_NOT_ALIGN] && !card_in_i)
               begin
                  nxt_q.blk_b = 1'b1;
                  nxt_q.attn  = 1'b1;
                  nxt_q.gate  = 1'b1;
               end
            default: ;
         endcase
      end
      if (card_in_i)
      begin
         nxt_q.blk_b = 1'b0;
         nxt_q.attn  = 1'b0;
         nxt_q.gate  = 1'b0;
      end

      // Start: busy rises in the cycle after the start write
      if (start_wr)
      begin
         nxt_q.seq        = st_feed;
         nxt_q.locate     = wdata_i[`CF_START_LOCATE];
         nxt_q.busy       = 1'b1;
         nxt_q.id_busy    = 1'b1;
         nxt_q.unit_chk   = 1'b0;
         nxt_q.drive_err  = 1'b0;
         nxt_q.mark_err   = 1'b0;
         nxt_q.clutch     = 1'b1;
         nxt_q.stop_req   = 1'b0;
         nxt_q.got_pulse  = 1'b0;
         nxt_q.line       = 8'h00;
         nxt_q.digit      = 4'h0;
         nxt_q.miss       = 2'd0;
         nxt_q.skip       = 1'b0;
         nxt_q.skip_wait  = 1'b0;
         nxt_q.eject_left = 8'(EJECT_LINES);
         nxt_q.timer      = 23'(DRIVE_CYC);
      end

      unique case (q.seq)
         st_idle: ;
         st_feed:
         begin
            // Motion watchdog until the first timing pulse
            if (!q.got_pulse)
            begin
               nxt_q.timer = q.timer - 23'd1;
               if (timing_pulse_i)
                  nxt_q.got_pulse = 1'b1;
               else if (q.timer == 23'd1)
               begin
                  nxt_q.drive_err = 1'b1;
                  nxt_q.unit_chk  = 1'b1;
                  nxt_q.clutch    = 1'b0;
                  nxt_q.seq       = st_hold;
                  nxt_q.timer     = 23'(HOLD_CYC);
               end
            end
            if (timing_pulse_i && q.line != 8'hFF)
               nxt_q.line = q.line + 8'h01;

            // Every ID byte goes to storage at the data address
            if (byte_valid)
            begin
               nxt_q.st    = '{req: 1'b1, addr: q.dat_a, data: id_byte};
               nxt_q.dat_a = q.dat_a + 16'h0001;
               nxt_q.digit = q.digit + 4'h1;
            end
            if (q.digit == 4'(ID_DIGITS) && !q.st.req)
               nxt_q.id_busy = 1'b0;

            // After the ID the two operations part ways
            if (line_pulse && past_id && !q.locate && !q.stop_req)
            begin
               nxt_q.eject_left = q.eject_left - 8'h01;
               if (q.eject_left == 8'h01)
                  nxt_q.stop_req = 1'b1;
            end
            if (line_pulse && past_id && q.locate)
            begin
               if (q.miss == 2'd2)
               begin
                  if (mark_i)
                  begin
                     nxt_q.mark_err = 1'b1;
                     nxt_q.unit_chk = 1'b1;
                     nxt_q.stop_req = 1'b1;
                  end
                  if (q.skip_wait)
                  begin
                     nxt_q.skip_wait = 1'b0;
                     nxt_q.stop_req  = 1'b1;
                  end
                  nxt_q.st = '{req: 1'b1, addr: q.lin_a, data: q.line};
               end
               else if (mark_i || mark_late_i)
               begin
                  nxt_q.miss = 2'd0;
                  if (mark_late_i)
                     nxt_q.skip = 1'b1;
               end
               else
               begin
                  nxt_q.miss = q.miss + 2'd1;
                  if (q.miss == 2'd1)
                  begin
                     // A blank card reaches here after its first two lines
                     nxt_q.st = '{req: 1'b1, addr: q.lin_a, data: q.line};
                     if (q.skip)
                        nxt_q.skip_wait = 1'b1;
                     else
                        nxt_q.stop_req = 1'b1;
                  end
               end
            end

            // Apart from a drive error, clutch drops only on a stop pulse so the armature meets the next tooth
            if (q.stop_req && stop_pulse_i)
            begin
               nxt_q.clutch = 1'b0;
               nxt_q.seq    = st_hold;
               nxt_q.timer  = 23'(HOLD_CYC);
            end
         end
         st_hold:
         begin
            // Busy outlasts the card motion by the hold time
            // ID busy stays up through the hold after a cut feed and drops with busy when the hold expires
            if (q.digit == 4'(ID_DIGITS) && !q.st.req)
               nxt_q.id_busy = 1'b0;
            if (q.timer != 23'd0)
               nxt_q.timer = q.timer - 23'd1;
            else if (!q.st.req)
            begin
               nxt_q.busy    = 1'b0;
               nxt_q.id_busy = 1'b0;
               nxt_q.seq     = st_idle;
            end
         end
      endcase

      // Read data stand in the cycle after the strobe only
      nxt_q.rdata = 16'h0000;
      if (rd_i)
      begin
         unique case (addr_i)
            `CF_OFS_CMD_ADDR:  nxt_q.rdata = q.cmd_a;
            `CF_OFS_DATA_ADDR: nxt_q.rdata = q.dat_a;
            `CF_OFS_LINE_ADDR: nxt_q.rdata = q.lin_a;
            `CF_OFS_STATUS:
               nxt_q.rdata = {9'h000, q.attn, q.mark_err, q.drive_err, q.unit_chk, q.clutch,
                              q.id_busy, q.busy};
            default:           nxt_q.rdata = 16'h0000;
         endcase
      end
   end

   // Reset returns every latch to idle
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         q       <= '0;
         q.cmd_a <= `CF_ADDR_RST;
         q.dat_a <= `CF_ADDR_RST;
         q.lin_a <= `CF_ADDR_RST;
      end
      else
         q <= nxt_q;
   end

   assign rdata_o           = q.rdata;
   assign clutch_o          = q.clutch;
   assign card_gate_raise_o = q.gate;
   assign attn_lamp_o       = q.attn;
   assign busy_o            = q.busy;
   assign block_cond_b_o    = q.blk_b;
   assign steal_req_o       = q.st.req;
   assign steal_addr_o      = q.st.addr;
   assign steal_data_o      = q.st.data;

   a_start_busy: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      start_wr |=> busy_o && clutch_o && q.id_busy)
      else $error("start did not set busy and clutch");

   a_busy_hold: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      $fell(busy_o) |-> $past(q.seq) == st_hold && $past(q.timer) == 23'd0)
      else $error("busy fell before hold expired");

   a_drive_check: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      $rose(q.drive_err) |-> !$past(q.got_pulse) && !clutch_o && q.unit_chk)
      else $error("drive error without missing pulse");

   a_stop_clutch: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (q.seq == st_feed && q.stop_req && stop_pulse_i) |=> !clutch_o ##1 !clutch_o)
      else $error("clutch kept running after stop pulse");

   a_second_miss: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (line_pulse && past_id && q.locate && q.miss == 2'd1 && !mark_i && !mark_late_i && !q.skip)
      |=> q.stop_req && steal_req_o && steal_addr_o == q.lin_a)
      else $error("second miss did not stop or steal");

   a_late_extra: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (line_pulse && past_id && q.locate && q.miss == 2'd1 && !mark_i && !mark_late_i && q.skip)
      |=> !q.stop_req && q.skip_wait)
      else $error("late mark did not add a line");

   a_eject_nomark: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (q.busy && !q.locate) |-> !q.mark_err && q.miss == 2'd0)
      else $error("eject examined marks");

   a_line_addr: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      $rose(steal_req_o) && !q.locate |-> steal_addr_o == $past(q.dat_a))
      else $error("eject used the line address");

   a_id_busy: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      $fell(q.id_busy) && busy_o |-> q.digit == 4'(ID_DIGITS) && !steal_req_o)
      else $error("id busy dropped early");

   a_test_gate: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (wr_i && addr_i == `CF_OFS_TEST && wdata_i[0] && !card_in_i) |=> block_cond_b_o && attn_lamp_o
      && card_gate_raise_o)
      else $error("not-aligned test missed gate or lamp");

endmodule

// ### verif/card_feed_mech.sv
// Purpose: Behavioural card feed mechanism with sense cells, facing the sequencer
// Assumes: One timing pulse every five cycles while the clutch pulls, stop pulse two cycles later
// Notes:   Sense lines toggle between pulses so a stale value is never mistaken for a reading
`timescale 1ns/1ps
module card_feed_mech
(
   // Clock, reset and clutch drive
   input  wire logic        clk_sys_i,
   input  wire logic        reset_i,
   input  wire logic        clutch_i,
   // Card contents and fault control
   input  wire logic [7:0]  id_nib_i,
   input  wire logic [15:0] mark_pat_i,
   input  wire logic [15:0] late_pat_i,
   input  wire logic        stall_i,
   // Sensed signals toward the attachment
   output logic             timing_pulse_o,
   output logic             stop_pulse_o,
   output logic [1:0]       id_bits_o,
   output logic             mark_o,
   output logic             mark_late_o,
   output logic [7:0]       lines_o
);
   logic [2:0] ph_ff;
   logic       clutch_ff;
   logic [2:0] d;
   logic [3:0] nib;

   // Digit and half read on the current line; high half on the first line of a digit
   always_comb
   begin
      d   = 3'(lines_o - 8'h02);
      nib = d[1] ? id_nib_i[7:4] : id_nib_i[3:0];
   end

   // A stalled drive gives no pulses at all, which is how a broken clutch looks
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         ph_ff          <= 3'h0;
         clutch_ff      <= 1'b0;
         timing_pulse_o <= 1'b0;
         stop_pulse_o   <= 1'b0;
         id_bits_o      <= 2'h0;
         mark_o         <= 1'b0;
         mark_late_o    <= 1'b0;
         lines_o        <= 8'h00;
      end
      else
      begin
         clutch_ff      <= clutch_i;
         timing_pulse_o <= 1'b0;
         stop_pulse_o   <= clutch_i && !stall_i && ph_ff == 3'h4;
         id_bits_o      <= ~id_bits_o;
         mark_o         <= ~mark_o;
         mark_late_o    <= ~mark_late_o;
         ph_ff          <= (!clutch_i || stall_i || ph_ff == 3'h4) ? 3'h0 : ph_ff + 3'h1;
         if (clutch_i && !clutch_ff)
            lines_o <= 8'h00;
         if (clutch_i && !stall_i && ph_ff == 3'h2)
         begin
            timing_pulse_o <= 1'b1;
            lines_o        <= lines_o + 8'h01;
            id_bits_o      <= d[0] ? nib[1:0] : nib[3:2];
            mark_o         <= mark_pat_i[lines_o[3:0]];
            mark_late_o    <= late_pat_i[lines_o[3:0]];
         end
      end
   end
endmodule

// ### verif/card_feed_seq_bench.sv
// Purpose: Self-checking bench for the card feed sequencer with a mechanism model
// Assumes: Short counts: two ID digits, eject run 4 lines, drive check 50, hold 20 cycles
// Notes:   Storage steals are acked one cycle after the request and logged for comparison
`timescale 1ns/1ps
`include "card_feed_consts.svh"
module card_feed_seq_bench import card_feed_pkg::*;;
   localparam logic [15:0] CMD = 16'h0300, DAT = 16'h0200, LIN = 16'h0410;
   localparam int HOLD = 20;
   logic clk_sys_i, reset_i, wr_i, rd_i, timing_pulse_i, stop_pulse_i, mark_i, mark_late_i, card_in_i;
   logic clutch_o, card_gate_raise_o, attn_lamp_o, busy_o, block_cond_b_o, steal_req_o, steal_ack_i, stall;
   logic [3:0]  addr_i;
   logic [15:0] wdata_i, rdata_o, steal_addr_o, mark_pat, late_pat, st;
   logic [1:0]  id_bits_i;
   logic [7:0]  steal_data_o, id_nib, lines;
   logic [15:0] qa[$];
   logic [7:0]  qd[$];
   int          n_mismatch = 0, tests_run = 0, h;

   card_feed_seq #(.ID_DIGITS(2), .ID_FIRST(2), .EJECT_LINES(4), .DRIVE_CYC(50), .HOLD_CYC(HOLD)) dut (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .timing_pulse_i(timing_pulse_i), .stop_pulse_i(stop_pulse_i),
      .id_bits_i(id_bits_i), .mark_i(mark_i), .mark_late_i(mark_late_i), .card_in_i(card_in_i),
      .clutch_o(clutch_o), .card_gate_raise_o(card_gate_raise_o), .attn_lamp_o(attn_lamp_o),
      .busy_o(busy_o), .block_cond_b_o(block_cond_b_o), .steal_req_o(steal_req_o),
      .steal_addr_o(steal_addr_o), .steal_data_o(steal_data_o), .steal_ack_i(steal_ack_i));

   card_feed_mech mech (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i), .clutch_i(clutch_o), .id_nib_i(id_nib),
      .mark_pat_i(mark_pat), .late_pat_i(late_pat), .stall_i(stall), .timing_pulse_o(timing_pulse_i),
      .stop_pulse_o(stop_pulse_i), .id_bits_o(id_bits_i), .mark_o(mark_i), .mark_late_o(mark_late_i),
      .lines_o(lines));

   // Clock, 10 ns period
   initial
   begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   // Storage side: ack each steal once, a cycle late, so the request must hold
   always @(posedge clk_sys_i)
   begin
      steal_ack_i <= 1'b0;
      if (steal_req_o === 1'b1 && steal_ack_i !== 1'b1)
      begin
         steal_ack_i <= 1'b1;
         qa.push_back(steal_addr_o);
         qd.push_back(steal_data_o);
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Bus tasks leave the bench one ns past a rising edge
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
      #1;
   endtask

   task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1;
      v = rdata_o;
   endtask

   // One feed operation from status test to end of hold
   task automatic run_op(input logic loc, input logic [7:0] nib, input logic [15:0] mk, input logic [15:0] lt);
      id_nib   = nib;
      mark_pat = mk;
      late_pat = lt;
      qa.delete();
      qd.delete();
      wr_reg(`CF_OFS_DATA_ADDR, DAT);
      rd_reg(`CF_OFS_STATUS, st);
      chk(st & 16'h0009, 16'h0000);
      wr_reg(`CF_OFS_START, {15'h0000, loc});
      chk({15'h0000, busy_o}, 16'h0001);
      rd_reg(`CF_OFS_STATUS, st);
      chk(st & 16'h0003, 16'h0003);
      for (h = 0; h < 500 && clutch_o === 1'b1; h++) #10;
      rd_reg(`CF_OFS_STATUS, st);
      chk(st & 16'h000F, 16'h0001);
      for (h = 2; h < 100 && busy_o === 1'b1; h++) #10;
      chk({15'h0000, h >= HOLD - 2 && h <= HOLD + 3}, 16'h0001);
   endtask

   // Steal log: two ID bytes, then an optional line steal
   task automatic chk_steals(input int n, input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] ln);
      chk(16'(qa.size()), 16'(n));
      chk(qa[0], DAT);
      chk(qa[1], DAT + 16'h0001);
      chk({8'h00, qd[0]}, {8'h00, b0});
      chk({8'h00, qd[1]}, {8'h00, b1});
      if (n == 3)
      begin
         chk(qa[2], LIN);
         chk({8'h00, qd[2]}, {8'h00, ln});
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Watchdog well past the few hundred cycles the tests need
   initial
   begin
      repeat (20000) @(posedge clk_sys_i);
      n_mismatch++;
      give_verdict();
   end

   initial
   begin
      {reset_i, wr_i, rd_i, card_in_i, stall} = 5'b10000;
      {addr_i, wdata_i, id_nib, mark_pat, late_pat} = '0;
      repeat (2) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      #1;
      rd_reg(`CF_OFS_STATUS, st);
      chk(st, 16'h0000);
      wr_reg(`CF_OFS_CMD_ADDR, CMD);
      wr_reg(`CF_OFS_LINE_ADDR, LIN);
      rd_reg(`CF_OFS_CMD_ADDR, st);
      chk(st, CMD);
      rd_reg(`CF_OFS_LINE_ADDR, st);
      chk(st, LIN);
      rd_reg(4'hF, st);
      chk(st, 16'h0000);
      $display("test registers done");
      wr_reg(`CF_OFS_TEST, 16'h0001);
      chk({13'h0000, card_gate_raise_o, attn_lamp_o, block_cond_b_o}, 16'h0007);
      @(posedge clk_sys_i);
      card_in_i <= 1'b1;
      #20;
      chk({13'h0000, card_gate_raise_o, attn_lamp_o, block_cond_b_o}, 16'h0000);
      $display("test card gate done");
      run_op(1'b1, 8'hFF, 16'h0000, 16'h0000);
      chk_steals(3, 8'h40, 8'h40, 8'h07);
      chk({8'h00, lines}, 16'h0008);
      $display("test blank locate done");
      run_op(1'b1, 8'h90, 16'h00C0, 16'h0000);
      chk_steals(3, 8'hF0, 8'hF9, 8'h09);
      chk({8'h00, lines}, 16'h000A);
      $display("test marked locate done");
      run_op(1'b1, 8'h35, 16'h0000, 16'h0040);
      chk({8'h00, lines}, 16'h000A);
      $display("test late mark done");
      run_op(1'b0, 8'h21, 16'h0000, 16'h0000);
      chk_steals(2, 8'hF1, 8'hF2, 8'h00);
      chk({15'h0000, lines >= 8'd10}, 16'h0001);
      $display("test eject done");
      stall = 1'b1;
      wr_reg(`CF_OFS_START, 16'h0001);
      for (h = 0; h < 200 && clutch_o === 1'b1; h++) #10;
      chk({15'h0000, h >= 46 && h <= 54}, 16'h0001);
      rd_reg(`CF_OFS_STATUS, st);
      chk(st & 16'h001C, 16'h0018);
      for (h = 0; h < 100 && busy_o === 1'b1; h++) #10;
      stall = 1'b0;
      $display("test drive check done");
      wr_reg(`CF_OFS_START, 16'h0001);
      repeat (12) @(posedge clk_sys_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      #1;
      chk({14'h0000, busy_o, clutch_o}, 16'h0000);
      rd_reg(`CF_OFS_STATUS, st);
      chk(st, 16'h0000);
      rd_reg(`CF_OFS_DATA_ADDR, st);
      chk(st, 16'h0000);
      $display("test mid-run reset done");
      give_verdict();
   end
endmodule
